// File: rtl/dlm_cfg.svh
// Register offsets, field positions, reset values and sizes of the limit/mask bank
// Notes on behaviour
// RULE1: Aux input one high limit becomes {hi,1111}; result above it is a fault.
// RULE2: Aux input one low limit becomes {lo,0000}; result below it is a fault.
// RULE3: Temperature high limit becomes {hi,1111}; result above it is a fault.
// RULE4: Temperature low limit becomes {lo,0000}; result below it is a fault.
// RULE5: Limit registers reset to high field all ones, low field zero.
// RULE6: FIFO write register carries a ninth bit, odd parity, sent with the byte.
// RULE7: FIFO write loads only from SPI with serial port disable set; else ignored.
// RULE8: Port select 0 (reset) gives SPI the map, 1 gives UART break.
// RULE9: Port select is written only through UART break access.
// RULE10: A fault whose mask bit is 0 may assert the interrupt request.
// RULE11: A fault whose mask bit is 1 reaches neither interrupt nor alarm.
// RULE12: Status bits follow fault conditions whatever the mask says.
// RULE13: Oscillator fail mask bit 12 and reference mask bit 5 reset to 0.
// RULE14: Mask bits 13, 8, 7, 6, 4, 3, 2 reset to 1.
// RULE15: Mask bit 1 gates over-temperature error; resets to 1.
// RULE16: Mask bit 0 gates temperature warning; resets to 1.
// RULE17: Oscillator fail pulls alarm low and never feeds the interrupt.
// RULE18: General summary is high while any unmasked general status bit is high.
// RULE19: Reserved bits read their fixed values; writes do not change them.
`ifndef DLM_CFG_SVH
`define DLM_CFG_SVH
`define DLM_OFS_AUX1 8'h13
`define DLM_OFS_TEMP 8'h14
`define DLM_OFS_FIFO 8'h15
`define DLM_OFS_PSEL 8'h16
`define DLM_OFS_AMASK 8'h1d
`define DLM_OFS_GMASK 8'h1e
`define DLM_RST_LIMITS 16'hff00
`define DLM_RST_FIFO 16'h0000
`define DLM_RST_PSEL 1'b0
`define DLM_RST_AMASK 16'hefdf
`define DLM_RST_GMASK 16'hffff
`define DLM_AMASK_WR 16'h31ff
`define DLM_GMASK_WR 16'h06cf
`define DLM_EXT_FLT 16'h31eb
`define DLM_IRQ_SRC 16'h2fff
`define DLM_BIT_OSC 12
`define DLM_BIT_AUX1 4
`define DLM_BIT_TEMP 2
`define DLM_BIT_PARITY 8
`define DLM_HI_MSB 15
`define DLM_HI_LSB 8
`define DLM_LO_MSB 7
`define DLM_LO_LSB 0
`define DLM_RES_W 12
`define DLM_LIM_W 8
`define DLM_FIFO_W 9
`define DLM_FIFO_D 16
`endif

// File: rtl/dlm_pkg.sv
// Shared types of the limit/mask bank
package dlm_pkg;
  typedef enum logic {DLM_PORT_SPI = 1'b0, DLM_PORT_UART = 1'b1} dlm_port_e;
  typedef logic [15:0] dlm_word_t;
  typedef logic [7:0] dlm_addr_t;
endpackage

// File: rtl/dlm_stream_if.sv
// Valid/ready stream carrier between the bank and its FIFO
`timescale 1ns/10ps
interface dlm_stream_if #(parameter int W = 9);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: rtl/dlm_fifo.sv
// Synchronous FIFO holding modem transmit characters
`timescale 1ns/10ps
module dlm_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  dlm_stream_if.snk push,
  dlm_stream_if.src pop
);
  localparam int AW = $clog2(D);
  // Pointer wrap bit only works for power-of-two depths
  if (D < 2 || (1 << AW) != D || W < 1) begin
    $error("dlm_fifo: depth must be a power of two of at least 2");
  end
  logic [W-1:0] mem [D];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire empty = (wp_q == rp_q);
  wire do_push = push.valid && !full;
  wire do_pop = pop.ready && !empty;
  assign push.ready = !full;
  assign pop.valid = !empty;
  assign pop.data = mem[rp_q[AW-1:0]];
  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem[wp_q[AW-1:0]] <= push.data;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_q + (AW+1)'(do_push);
      rp_q <= rp_q + (AW+1)'(do_pop);
    end
  end
  property p_full_holds;
    @(posedge ref_clk) disable iff (rst) full && !do_pop |=> full;
  endproperty
  a_full_holds: assert property (p_full_holds) else $error("FIFO full lost without pop");
endmodule

// File: rtl/dlm_limit_chk.sv
// Window compare of one diagnostic result against an 8-bit limit pair
`timescale 1ns/10ps
module dlm_limit_chk #(
  parameter int RES_W = 12,
  parameter int LIM_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [LIM_W-1:0] lim_hi,
  input wire logic [LIM_W-1:0] lim_lo,
  input wire logic [RES_W-1:0] res,
  input wire logic res_valid,
  output logic hi_flt,
  output logic lo_flt
);
  if (RES_W <= LIM_W) begin
    $error("dlm_limit_chk: result must be wider than the limit");
  end
  // Padding makes the high limit inclusive of its whole step
  wire [RES_W-1:0] hi_full = {lim_hi, {(RES_W-LIM_W){1'b1}}}; // RULE1
  wire [RES_W-1:0] lo_full = {lim_lo, {(RES_W-LIM_W){1'b0}}}; // RULE2
  wire over = res > hi_full; // RULE1
  wire under = res < lo_full; // RULE2
  // Verdict stands until the next conversion of this channel
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hi_flt <= 1'b0;
      lo_flt <= 1'b0;
    end else if (res_valid) begin
      hi_flt <= over;
      lo_flt <= under;
    end
  end
  property p_hi_flt;
    @(posedge ref_clk) disable iff (rst)
      res_valid |=> hi_flt == (($past(res) > {$past(lim_hi), 4'hf}) ? 1'b1 : 1'b0);
  endproperty
  a_hi_flt: assert property (p_hi_flt) else $error("High limit verdict wrong"); // RULE1
  property p_lo_flt;
    @(posedge ref_clk) disable iff (rst)
      res_valid && res < {lim_lo, 4'h0} |=> lo_flt;
  endproperty
  a_lo_flt: assert property (p_lo_flt) else $error("Low limit fault missed"); // RULE2
endmodule

// File: rtl/dlm_bank.sv
// Diagnostic limit, modem FIFO write, port select and fault mask registers
`timescale 1ns/10ps
`include "dlm_cfg.svh"
module dlm_bank
  import dlm_pkg::*;
#(
  parameter int FIFO_W = `DLM_FIFO_W,
  parameter int FIFO_D = `DLM_FIFO_D
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire dlm_port_e reg_src,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic serial_port_disable,
  output logic fifo_wr_ready,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [8:0] tx_data,
  input wire logic [11:0] aux1_res,
  input wire logic aux1_valid,
  input wire logic [11:0] temp_res,
  input wire logic temp_valid,
  input wire logic [15:0] ext_fault,
  input wire logic [15:0] gen_status,
  output logic [15:0] flt_status,
  output logic general_irq_summary,
  output logic reg_mode,
  output logic irq,
  output logic alarm_n
);
  // Transmit port is fixed at byte plus parity
  if (FIFO_W != `DLM_FIFO_W || FIFO_D < 2) begin
    $error("dlm_bank: FIFO must be 9 bits wide and at least 2 deep");
  end

  dlm_word_t aux1_q, aux1_d;
  dlm_word_t temp_q, temp_d;
  dlm_word_t amask_q, amask_d;
  dlm_word_t gmask_q, gmask_d;
  dlm_word_t rdata_q, rdata_d;
  dlm_word_t flt_q;
  logic psel_q, psel_d;
  logic gsum_q, irq_q, alarm_n_q;
  logic aux1_hi, aux1_lo, temp_hi, temp_lo;

  // Address decode
  wire hit_aux1 = reg_addr == `DLM_OFS_AUX1;
  wire hit_temp = reg_addr == `DLM_OFS_TEMP;
  wire hit_fifo = reg_addr == `DLM_OFS_FIFO;
  wire hit_psel = reg_addr == `DLM_OFS_PSEL;
  wire hit_amask = reg_addr == `DLM_OFS_AMASK;
  wire hit_gmask = reg_addr == `DLM_OFS_GMASK;
  // Only the selected port reaches the map; port select itself stays open
  wire map_ok = (reg_src == DLM_PORT_UART) == psel_q; // RULE8
  wire wr_map = reg_wr && map_ok;
  wire wr_aux1 = wr_map && hit_aux1;
  wire wr_temp = wr_map && hit_temp;
  wire wr_amask = wr_map && hit_amask;
  wire wr_gmask = wr_map && hit_gmask;
  wire wr_psel = reg_wr && hit_psel && reg_src == DLM_PORT_UART; // RULE9
  // A write while the FIFO is full is dropped; the host watches fifo_wr_ready
  wire wr_fifo = wr_map && hit_fifo && reg_src == DLM_PORT_SPI
    && serial_port_disable; // RULE7

  assign aux1_d = wr_aux1 ? reg_wdata : aux1_q;
  assign temp_d = wr_temp ? reg_wdata : temp_q;
  assign psel_d = wr_psel ? reg_wdata[0] : psel_q; // RULE9
  // Reserved bits keep their fixed pattern through any write
  assign amask_d = wr_amask
    ? ((reg_wdata & `DLM_AMASK_WR) | (`DLM_RST_AMASK & ~`DLM_AMASK_WR)) : amask_q; // RULE19
  assign gmask_d = wr_gmask
    ? ((reg_wdata & `DLM_GMASK_WR) | (`DLM_RST_GMASK & ~`DLM_GMASK_WR)) : gmask_q; // RULE19

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aux1_q <= `DLM_RST_LIMITS; // RULE5
      temp_q <= `DLM_RST_LIMITS; // RULE5
      psel_q <= `DLM_RST_PSEL; // RULE8
      amask_q <= `DLM_RST_AMASK; // RULE13 RULE14 RULE15 RULE16
      gmask_q <= `DLM_RST_GMASK;
    end else begin
      aux1_q <= aux1_d;
      temp_q <= temp_d;
      psel_q <= psel_d;
      amask_q <= amask_d;
      gmask_q <= gmask_d;
    end
  end

  // Read side; the FIFO write register is write-only and reads zero
  wire [15:0] rd_aux1 = hit_aux1 ? aux1_q : 16'h0000;
  wire [15:0] rd_temp = hit_temp ? temp_q : 16'h0000;
  wire [15:0] rd_psel = hit_psel ? {15'h0000, psel_q} : 16'h0000;
  wire [15:0] rd_amask = hit_amask ? amask_q : 16'h0000;
  wire [15:0] rd_gmask = hit_gmask ? gmask_q : 16'h0000;
  wire [15:0] rd_map = map_ok ? (rd_aux1 | rd_temp | rd_amask | rd_gmask) : 16'h0000;
  assign rdata_d = reg_rd ? (rd_map | rd_psel) : rdata_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;
  assign reg_mode = psel_q;

  // Window compares on the two diagnostic channels
  dlm_limit_chk #(.RES_W(`DLM_RES_W), .LIM_W(`DLM_LIM_W)) u_aux1 (
    .ref_clk(ref_clk),
    .rst(rst),
    .lim_hi(aux1_q[`DLM_HI_MSB:`DLM_HI_LSB]),
    .lim_lo(aux1_q[`DLM_LO_MSB:`DLM_LO_LSB]),
    .res(aux1_res),
    .res_valid(aux1_valid),
    .hi_flt(aux1_hi),
    .lo_flt(aux1_lo)
  );
  dlm_limit_chk #(.RES_W(`DLM_RES_W), .LIM_W(`DLM_LIM_W)) u_temp (
    .ref_clk(ref_clk),
    .rst(rst),
    .lim_hi(temp_q[`DLM_HI_MSB:`DLM_HI_LSB]), // RULE3
    .lim_lo(temp_q[`DLM_LO_MSB:`DLM_LO_LSB]), // RULE4
    .res(temp_res),
    .res_valid(temp_valid),
    .hi_flt(temp_hi),
    .lo_flt(temp_lo)
  );

  // Fault status is unmasked; masks only act on irq, alarm and the general summary
  wire [15:0] limit_flt = (16'(aux1_hi | aux1_lo) << `DLM_BIT_AUX1)
    | (16'(temp_hi | temp_lo) << `DLM_BIT_TEMP);
  wire [15:0] flt_d = (ext_fault & `DLM_EXT_FLT) | limit_flt; // RULE12
  wire [15:0] live_flt = flt_q & ~amask_q; // RULE10 RULE11
  // Oscillator fail is left out of the interrupt sources
  wire irq_d = |(live_flt & `DLM_IRQ_SRC) || gsum_q; // RULE17
  wire alarm_d = |live_flt; // RULE11
  wire [15:0] gen_live = gen_status & ~gmask_q;
  wire gsum_d = |gen_live; // RULE18

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flt_q <= 16'h0000;
      gsum_q <= 1'b0;
      irq_q <= 1'b0;
      alarm_n_q <= 1'b1;
    end else begin
      flt_q <= flt_d; // RULE12
      gsum_q <= gsum_d; // RULE18
      irq_q <= irq_d; // RULE10
      alarm_n_q <= ~alarm_d; // RULE17
    end
  end
  assign flt_status = flt_q;
  assign general_irq_summary = gsum_q;
  assign irq = irq_q;
  assign alarm_n = alarm_n_q;

  // Modem transmit FIFO: byte in bits 7..0, odd parity in bit 8
  dlm_stream_if #(.W(FIFO_W)) s_push ();
  dlm_stream_if #(.W(FIFO_W)) s_pop ();
  assign s_push.valid = wr_fifo; // RULE7
  assign s_push.data = reg_wdata[`DLM_BIT_PARITY:0]; // RULE6
  assign fifo_wr_ready = s_push.ready;
  assign tx_valid = s_pop.valid;
  assign tx_data = s_pop.data;
  assign s_pop.ready = tx_ready;
  dlm_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .push(s_push),
    .pop(s_pop)
  );

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_fifo_wr_ok;
    reg_wr && hit_fifo && reg_src == DLM_PORT_SPI && serial_port_disable && map_ok;
  endsequence
  sequence s_fifo_wr_bad;
    reg_wr && hit_fifo && (reg_src == DLM_PORT_UART || !serial_port_disable);
  endsequence
  property p_fifo_data;
    s_fifo_wr_ok |-> s_push.valid && s_push.data == reg_wdata[8:0];
  endproperty
  a_fifo_data: assert property (p_fifo_data) else $error("FIFO write lost data or parity"); // RULE6
  property p_fifo_ignore;
    s_fifo_wr_bad |-> !s_push.valid;
  endproperty
  a_fifo_ignore: assert property (p_fifo_ignore) else $error("Illegal FIFO write taken"); // RULE7
  property p_psel_spi;
    reg_wr && hit_psel && reg_src == DLM_PORT_SPI |=> $stable(psel_q);
  endproperty
  a_psel_spi: assert property (p_psel_spi) else $error("Port select changed from SPI"); // RULE9
  property p_map_gate;
    reg_wr && hit_aux1 && !map_ok |=> $stable(aux1_q);
  endproperty
  a_map_gate: assert property (p_map_gate) else $error("Unselected port wrote the map"); // RULE8
  property p_temp_hi;
    temp_valid && temp_res > {temp_q[15:8], 4'hf} |=> ##1 flt_q[`DLM_BIT_TEMP];
  endproperty
  a_temp_hi: assert property (p_temp_hi) else $error("Temperature over-limit missed"); // RULE3
  property p_temp_lo;
    temp_valid && temp_res < {temp_q[7:0], 4'h0} |=> ##1 flt_q[`DLM_BIT_TEMP];
  endproperty
  a_temp_lo: assert property (p_temp_lo) else $error("Temperature under-limit missed"); // RULE4
  property p_limit_rst;
    $past(rst) |-> aux1_q == 16'hff00 && temp_q == 16'hff00;
  endproperty
  a_limit_rst: assert property (p_limit_rst) else $error("Limit reset value wrong"); // RULE5
  property p_mask_rst0;
    $past(rst) |-> !amask_q[12] && !amask_q[5];
  endproperty
  a_mask_rst0: assert property (p_mask_rst0) else $error("Unmasked bits reset wrong"); // RULE13
  property p_mask_rst1;
    $past(rst) |-> amask_q[13] && amask_q[8] && amask_q[7] && amask_q[6]
      && amask_q[4] && amask_q[3] && amask_q[2];
  endproperty
  a_mask_rst1: assert property (p_mask_rst1) else $error("Masked bits reset wrong"); // RULE14
  property p_mask_err;
    $past(rst) |-> amask_q[1];
  endproperty
  a_mask_err: assert property (p_mask_err) else $error("Error mask reset wrong"); // RULE15
  property p_mask_warn;
    $past(rst) |-> amask_q[0];
  endproperty
  a_mask_warn: assert property (p_mask_warn) else $error("Warning mask reset wrong"); // RULE16
  property p_unmasked_irq;
    flt_q[6] && !amask_q[6] |=> irq;
  endproperty
  a_unmasked_irq: assert property (p_unmasked_irq) else $error("Unmasked fault gave no irq"); // RULE10
  property p_masked_quiet;
    live_flt == 16'h0000 && !gsum_q |=> irq == 1'b0 && alarm_n == 1'b1;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("Masked fault escaped"); // RULE11
  property p_osc_alarm;
    flt_q[12] && !amask_q[12] && (live_flt & 16'hefff) == 16'h0000 && !gsum_q
      |=> !alarm_n && !irq;
  endproperty
  a_osc_alarm: assert property (p_osc_alarm) else $error("Oscillator fail routed wrong"); // RULE17
  property p_status_raw;
    ext_fault[13] && amask_q[13] |=> flt_q[13];
  endproperty
  a_status_raw: assert property (p_status_raw) else $error("Masked status not set"); // RULE12
  property p_gen_sum;
    (gen_status & ~gmask_q) != 16'h0000 |=> general_irq_summary;
  endproperty
  a_gen_sum: assert property (p_gen_sum) else $error("General summary missed"); // RULE18
  property p_reserved;
    reg_rd && hit_amask && map_ok |=> reg_rdata[15:14] == 2'b11 && reg_rdata[11:9] == 3'b111;
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved mask bits read wrong"); // RULE19
  // Limit verdicts reach the status word two edges after the strobe
  sequence s_aux1_over;
    aux1_valid && aux1_res > {aux1_q[`DLM_HI_MSB:`DLM_HI_LSB], 4'hf};
  endsequence
  sequence s_aux1_under;
    aux1_valid && aux1_res < {aux1_q[`DLM_LO_MSB:`DLM_LO_LSB], 4'h0};
  endsequence
  property p_aux1_hi;
    s_aux1_over |=> ##1 flt_q[`DLM_BIT_AUX1];
  endproperty
  a_aux1_hi: assert property (p_aux1_hi) else $error("Aux one over-limit missed"); // RULE1
  property p_aux1_lo;
    s_aux1_under |=> ##1 flt_q[`DLM_BIT_AUX1];
  endproperty
  a_aux1_lo: assert property (p_aux1_lo) else $error("Aux one under-limit missed"); // RULE2
  property p_psel_uart;
    reg_wr && hit_psel && reg_src == DLM_PORT_UART |=> psel_q == $past(reg_wdata[0]);
  endproperty
  a_psel_uart: assert property (p_psel_uart) else $error("Port select write lost"); // RULE9
  property p_psel_rst;
    $past(rst) |-> psel_q == `DLM_RST_PSEL;
  endproperty
  a_psel_rst: assert property (p_psel_rst) else $error("Port select reset wrong"); // RULE8
  property p_map_write;
    reg_wr && hit_aux1 && map_ok |=> aux1_q == $past(reg_wdata);
  endproperty
  a_map_write: assert property (p_map_write) else $error("Selected port write lost"); // RULE8
  property p_map_read;
    reg_rd && hit_aux1 && !map_ok |=> reg_rdata == 16'h0000;
  endproperty
  a_map_read: assert property (p_map_read) else $error("Unselected port read map"); // RULE8
  property p_fifo_push;
    s_fifo_wr_ok && fifo_wr_ready |=> tx_valid;
  endproperty
  a_fifo_push: assert property (p_fifo_push) else $error("FIFO write not queued"); // RULE7
  property p_amask_resv;
    wr_amask |=> amask_q[15:14] == 2'b11 && amask_q[11:9] == 3'b111;
  endproperty
  a_amask_resv: assert property (p_amask_resv) else $error("Alarm mask reserved wrong"); // RULE19
  property p_gmask_resv;
    wr_gmask |=> gmask_q[15:11] == 5'h1f && gmask_q[8] && gmask_q[5:4] == 2'b11;
  endproperty
  a_gmask_resv: assert property (p_gmask_resv) else $error("Gen mask reserved wrong"); // RULE19
  property p_alarm_live;
    live_flt != 16'h0000 |=> !alarm_n;
  endproperty
  a_alarm_live: assert property (p_alarm_live) else $error("Unmasked fault gave no alarm"); // RULE10
endmodule

// File: testbench/dlm_modem_model.sv
// Modem side that takes transmit characters from the bank, with stalls
`timescale 1ns/10ps
module dlm_modem_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hold,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [8:0] tx_data,
  output logic tx_ready
);
  logic [8:0] rx_q[$];
  // Slow mode drops ready every other cycle to exercise back-pressure
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= !hold && !(slow && tx_ready);
      if (tx_valid && tx_ready) begin
        rx_q.push_back(tx_data);
      end
    end
  end
endmodule

// File: testbench/dlm_bank_test.sv
// Self-checking bench for the limit, FIFO write, port select and mask bank
`timescale 1ns/10ps
module dlm_bank_test
  import dlm_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  dlm_port_e reg_src = DLM_PORT_SPI;
  dlm_addr_t reg_addr = 8'h00;
  dlm_word_t reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic serial_port_disable = 1'b0;
  logic fifo_wr_ready;
  logic tx_valid;
  logic tx_ready;
  logic [8:0] tx_data;
  logic [11:0] aux1_res = 12'h000;
  logic aux1_valid = 1'b0;
  logic [11:0] temp_res = 12'h000;
  logic temp_valid = 1'b0;
  logic [15:0] ext_fault = 16'h0000;
  logic [15:0] gen_status = 16'h0000;
  logic [15:0] flt_status;
  logic general_irq_summary;
  logic reg_mode;
  logic irq;
  logic alarm_n;
  logic hold = 1'b1;
  logic slow = 1'b0;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  dlm_addr_t rst_addr[7] = '{8'h13, 8'h14, 8'h15, 8'h16, 8'h1d, 8'h1e, 8'h20};
  dlm_word_t rst_val[7] = '{16'hff00, 16'hff00, 16'h0, 16'h0, 16'hefdf, 16'hffff, 16'h0};
  // Bit 12 picks the temperature channel, low 12 bits are the result
  logic [15:0] cases[10] = '{16'h0fff, 16'h0000, 16'h0810, 16'h080f, 16'h03ff,
                             16'h0400, 16'h1810, 16'h180f, 16'h13ff, 16'h1400};
  logic [1:0] ev[10] = '{2'b00, 2'b00, 2'b10, 2'b00, 2'b10, 2'b00, 2'b11, 2'b00, 2'b11, 2'b00};

  always #12.5 ref_clk = ~ref_clk;

  dlm_bank i_dut (.ref_clk, .rst, .reg_wr, .reg_rd, .reg_src, .reg_addr, .reg_wdata,
    .reg_rdata, .serial_port_disable, .fifo_wr_ready, .tx_valid, .tx_ready, .tx_data,
    .aux1_res, .aux1_valid, .temp_res, .temp_valid, .ext_fault, .gen_status, .flt_status,
    .general_irq_summary, .reg_mode, .irq, .alarm_n);

  dlm_modem_model i_modem (.ref_clk, .rst, .hold, .slow, .tx_valid, .tx_data, .tx_ready);

  task automatic results();
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input dlm_port_e s, input dlm_addr_t a, input dlm_word_t d);
    @(posedge ref_clk);
    reg_src <= s;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    settle(1);
  endtask

  task automatic rd(input dlm_port_e s, input dlm_addr_t a, input dlm_word_t exp);
    @(posedge ref_clk);
    reg_src <= s;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    settle(1);
    chk($sformatf("register %h", a), exp, reg_rdata);
  endtask

  task automatic diag(input logic [15:0] c);
    @(posedge ref_clk);
    if (c[12]) begin
      temp_res <= c[11:0];
      temp_valid <= 1'b1;
    end else begin
      aux1_res <= c[11:0];
      aux1_valid <= 1'b1;
    end
    @(posedge ref_clk);
    temp_valid <= 1'b0;
    aux1_valid <= 1'b0;
    settle(4);
  endtask

  function automatic logic [8:0] word(input int i);
    logic [7:0] b;
    b = 8'h30 + 8'(i);
    return {~^b, b};
  endfunction

  // Cut a hang short well beyond the few hundred cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      results();
    end
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(DLM_PORT_SPI, rst_addr[i], rst_val[i]);
    end
    for (int i = 0; i < 10; i++) begin
      if (i == 2) begin
        wr(DLM_PORT_SPI, 8'h13, 16'h8040);
        wr(DLM_PORT_SPI, 8'h14, 16'h8040);
        wr(DLM_PORT_SPI, 8'h1d, 16'hefdb);
      end
      diag(cases[i]);
      chk("limit fault", {15'h0, ev[i][1]}, {15'h0, flt_status[cases[i][12] ? 2 : 4]});
      chk("irq", {15'h0, ev[i][0]}, {15'h0, irq});
      chk("alarm_n", {15'h0, !ev[i][0]}, {15'h0, alarm_n});
    end
    @(posedge ref_clk);
    ext_fault <= 16'h1000;
    settle(3);
    chk("status", 16'h1000, flt_status);
    chk("irq", 16'h0, {15'h0, irq});
    chk("alarm_n", 16'h0, {15'h0, alarm_n});
    @(posedge ref_clk);
    ext_fault <= 16'h2040;
    settle(3);
    chk("status", 16'h2040, flt_status);
    chk("alarm_n", 16'h1, {15'h0, alarm_n});
    wr(DLM_PORT_SPI, 8'h1d, 16'h0000);
    settle(3);
    chk("irq", 16'h1, {15'h0, irq});
    chk("alarm_n", 16'h0, {15'h0, alarm_n});
    rd(DLM_PORT_SPI, 8'h1d, 16'hce00);
    wr(DLM_PORT_SPI, 8'h1d, 16'hffff);
    rd(DLM_PORT_SPI, 8'h1d, 16'hffff);
    @(posedge ref_clk);
    ext_fault <= 16'h0000;
    gen_status <= 16'h0001;
    settle(3);
    chk("summary", 16'h0, {15'h0, general_irq_summary});
    chk("irq", 16'h0, {15'h0, irq});
    wr(DLM_PORT_SPI, 8'h1e, 16'h0000);
    settle(3);
    chk("summary", 16'h1, {15'h0, general_irq_summary});
    chk("irq", 16'h1, {15'h0, irq});
    rd(DLM_PORT_SPI, 8'h1e, 16'hf930);
    wr(DLM_PORT_SPI, 8'h1e, 16'hffff);
    @(posedge ref_clk);
    gen_status <= 16'h0000;
    serial_port_disable <= 1'b1;
    wr(DLM_PORT_SPI, 8'h16, 16'h0001);
    rd(DLM_PORT_SPI, 8'h16, 16'h0000);
    wr(DLM_PORT_UART, 8'h13, 16'h1234);
    wr(DLM_PORT_UART, 8'h16, 16'h0001);
    chk("reg_mode", 16'h1, {15'h0, reg_mode});
    rd(DLM_PORT_SPI, 8'h13, 16'h0000);
    rd(DLM_PORT_UART, 8'h13, 16'h8040);
    wr(DLM_PORT_UART, 8'h15, 16'h0155);
    chk("tx_valid", 16'h0, {15'h0, tx_valid});
    wr(DLM_PORT_UART, 8'h16, 16'h0000);
    chk("reg_mode", 16'h0, {15'h0, reg_mode});
    @(posedge ref_clk);
    serial_port_disable <= 1'b0;
    wr(DLM_PORT_SPI, 8'h15, 16'h0155);
    chk("tx_valid", 16'h0, {15'h0, tx_valid});
    @(posedge ref_clk);
    serial_port_disable <= 1'b1;
    // Back-to-back writes; the seventeenth meets a full buffer and is dropped
    for (int i = 0; i < 17; i++) begin
      reg_src <= DLM_PORT_SPI;
      reg_addr <= 8'h15;
      reg_wdata <= {7'h0, word(i)};
      reg_wr <= 1'b1;
      @(posedge ref_clk);
    end
    reg_wr <= 1'b0;
    settle(1);
    chk("fifo_wr_ready", 16'h0, {15'h0, fifo_wr_ready});
    chk("tx_data", {7'h0, word(0)}, {7'h0, tx_data});
    @(posedge ref_clk);
    hold <= 1'b0;
    slow <= 1'b1;
    for (int k = 0; k < 200 && i_modem.rx_q.size() < 16; k++) begin
      @(posedge ref_clk);
    end
    settle(4);
    chk("received count", 16'd16, 16'(i_modem.rx_q.size()));
    for (int i = 0; i < 16 && i < i_modem.rx_q.size(); i++) begin
      chk($sformatf("word %0d", i), {7'h0, word(i)}, {7'h0, i_modem.rx_q[i]});
    end
    chk("tx_valid", 16'h0, {15'h0, tx_valid});
    chk("fifo_wr_ready", 16'h1, {15'h0, fifo_wr_ready});
    results();
  end
endmodule
